// ---- hdl/adw_window_detector.sv ----
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "adw_regs.svh"

// Contract
// R1: every new first-converter result is tested; a match sets the window flag.
// R2: the window flag is readable as a status bit for polling.
// R3: two 16-bit limits, upper and lower, each written as high and low bytes.
// R4: single-ended mode compares limits against the converter output word.
// R5: differential mode compares signed two's complement results, 0x8000 to 0x7FFF.
// R6: inside or outside window chosen only by relative limit values.
// R7: lower 0xFFFF, upper 0x1000 differential flags results below -1 or above 0x1000.
// R8: upper below lower flags strictly between; else outside; misses leave flag alone.
module adw_window_detector (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  // register port
  input  wire logic [3:0]            regAddr,
  input  wire logic [7:0]            regWrData,
  input  wire logic                  regWrEn,
  input  wire logic                  regRdEn,
  output logic      [7:0]            regRdData,
  // converter result path
  input  wire adw_pkg::adw_result_t  convResult,
  // status out
  output logic                       windowHitFlag,
  output logic                       windowHitPulse,
  output logic                       diffModeOut
);

  // register port bundle
  adw_pkg::adw_reg_req_t regReq;

  assign regReq.addr   = regAddr;
  assign regReq.wrData = regWrData;
  assign regReq.wrEn   = regWrEn;
  assign regReq.rdEn   = regRdEn;

  // write decodes
  logic wrGtHigh;
  logic wrGtLow;
  logic wrLtHigh;
  logic wrLtLow;
  logic wrControl;
  logic wrStatus;
  logic wrHitCount;

  assign wrGtHigh   = regReq.wrEn && (regReq.addr == `ADW_OFF_GT_HIGH);
  assign wrGtLow    = regReq.wrEn && (regReq.addr == `ADW_OFF_GT_LOW);
  assign wrLtHigh   = regReq.wrEn && (regReq.addr == `ADW_OFF_LT_HIGH);
  assign wrLtLow    = regReq.wrEn && (regReq.addr == `ADW_OFF_LT_LOW);
  assign wrControl  = regReq.wrEn && (regReq.addr == `ADW_OFF_CONTROL);
  assign wrStatus   = regReq.wrEn && (regReq.addr == `ADW_OFF_STATUS);
  assign wrHitCount = regReq.wrEn && (regReq.addr == `ADW_OFF_HIT_COUNT);

  // limit words
  adw_pkg::adw_limits_t limits;

  adw_byte_pair #(
    .RST_HIGH (`ADW_RST_GT_HIGH),
    .RST_LOW  (`ADW_RST_GT_LOW)
  ) u_upper (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .wrHigh  (wrGtHigh),
    .wrLow   (wrGtLow),
    .wrData  (regReq.wrData),
    .word    (limits.upper)
  ); // R3

  adw_byte_pair #(
    .RST_HIGH (`ADW_RST_LT_HIGH),
    .RST_LOW  (`ADW_RST_LT_LOW)
  ) u_lower (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .wrHigh  (wrLtHigh),
    .wrLow   (wrLtLow),
    .wrData  (regReq.wrData),
    .word    (limits.lower)
  ); // R3

  // control register: mode and detector enable
  logic [7:0] control_reg;
  logic       diffMode;
  logic       detectEnable;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      control_reg <= `ADW_RST_CONTROL;
    end else if (wrControl) begin
      control_reg <= regReq.wrData & `ADW_CTL_MASK;
    end
  end

  assign diffMode     = control_reg[`ADW_CTL_DIFF_BIT];
  assign detectEnable = control_reg[`ADW_CTL_ENABLE_BIT];

  // window test on the incoming result
  logic rawHit;
  logic newResult;
  logic hitEvent;

  adw_window_compare u_compare (
    .diffMode (diffMode),
    .result   (convResult.word),
    .limits   (limits),
    .hit      (rawHit)
  ); // R4 R5 R6 R7 R8

  // each valid strobe is one fresh conversion
  assign newResult = convResult.valid && detectEnable; // R1
  assign hitEvent  = newResult && rawHit; // R1

  // window hit flag: sticky, write one to clear, a set in the same cycle wins
  logic hitFlag_reg;
  logic hitFlag_next;
  logic clearHit;

  assign clearHit = wrStatus && regReq.wrData[`ADW_STS_HIT_BIT];

  always_comb begin
    hitFlag_next = hitFlag_reg;
    if (clearHit) begin
      hitFlag_next = 1'b0;
    end
    if (hitEvent) begin
      hitFlag_next = 1'b1; // R8
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hitFlag_reg <= 1'b0;
    end else begin
      hitFlag_reg <= hitFlag_next; // R1
    end
  end

  // counter of hits; saturates and raises a sticky overflow bit
  logic [7:0] hitCount_reg;
  logic [7:0] hitCount_next;
  logic       hitOverflow_reg;
  logic       hitOverflow_next;
  logic       clearOverflow;

  assign clearOverflow = wrStatus && regReq.wrData[`ADW_STS_OVF_BIT];

  always_comb begin
    hitCount_next = hitCount_reg;
    if (wrHitCount) begin
      hitCount_next = regReq.wrData;
    end else if (hitEvent && (hitCount_reg != `ADW_CNT_MAX)) begin
      hitCount_next = hitCount_reg + `ADW_CNT_ONE;
    end
  end

  always_comb begin
    hitOverflow_next = hitOverflow_reg;
    if (clearOverflow) begin
      hitOverflow_next = 1'b0;
    end
    if (hitEvent && (hitCount_reg == `ADW_CNT_MAX)) begin
      hitOverflow_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hitCount_reg <= `ADW_RST_BYTE;
    end else begin
      hitCount_reg <= hitCount_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hitOverflow_reg <= 1'b0;
    end else begin
      hitOverflow_reg <= hitOverflow_next;
    end
  end

  // last tested result, kept for software to inspect
  logic [15:0] lastResult_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lastResult_reg <= `ADW_RST_WORD;
    end else if (newResult) begin
      lastResult_reg <= convResult.word;
    end
  end

  // status byte view
  logic [7:0] statusByte;

  always_comb begin
    statusByte = `ADW_RST_BYTE;
    statusByte[`ADW_STS_HIT_BIT] = hitFlag_reg; // R2
    statusByte[`ADW_STS_OVF_BIT] = hitOverflow_reg;
  end

  // read mux; unmapped offsets return zero
  logic [7:0] readValue;

  always_comb begin
    unique case (regReq.addr)
      `ADW_OFF_GT_HIGH: begin
        readValue = limits.upper[15:8];
      end
      `ADW_OFF_GT_LOW: begin
        readValue = limits.upper[7:0];
      end
      `ADW_OFF_LT_HIGH: begin
        readValue = limits.lower[15:8];
      end
      `ADW_OFF_LT_LOW: begin
        readValue = limits.lower[7:0];
      end
      `ADW_OFF_CONTROL: begin
        readValue = control_reg;
      end
      `ADW_OFF_STATUS: begin
        readValue = statusByte; // R2
      end
      `ADW_OFF_RESULT_HIGH: begin
        readValue = lastResult_reg[15:8];
      end
      `ADW_OFF_RESULT_LOW: begin
        readValue = lastResult_reg[7:0];
      end
      `ADW_OFF_HIT_COUNT: begin
        readValue = hitCount_reg;
      end
      default: begin
        readValue = `ADW_RST_BYTE;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      regRdData <= `ADW_RST_BYTE;
    end else if (regReq.rdEn) begin
      regRdData <= readValue;
    end else begin
      regRdData <= `ADW_RST_BYTE;
    end
  end

  // outputs straight from flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      windowHitPulse <= 1'b0;
    end else begin
      windowHitPulse <= hitEvent; // R1
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      windowHitFlag <= 1'b0;
    end else begin
      windowHitFlag <= hitFlag_next; // R2
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      diffModeOut <= 1'b0;
    end else begin
      diffModeOut <= diffMode;
    end
  end

endmodule

// ---- hdl/adw_regs.svh ----
`ifndef ADW_REGS_SVH
`define ADW_REGS_SVH

// register offsets on the byte-wide register port
`define ADW_OFF_GT_HIGH      4'h0
`define ADW_OFF_GT_LOW       4'h1
`define ADW_OFF_LT_HIGH      4'h2
`define ADW_OFF_LT_LOW       4'h3
`define ADW_OFF_CONTROL      4'h4
`define ADW_OFF_STATUS       4'h5
`define ADW_OFF_RESULT_HIGH  4'h6
`define ADW_OFF_RESULT_LOW   4'h7
`define ADW_OFF_HIT_COUNT    4'h8

// reset values
`define ADW_RST_GT_HIGH      8'hFF
`define ADW_RST_GT_LOW       8'hFF
`define ADW_RST_LT_HIGH      8'h00
`define ADW_RST_LT_LOW       8'h00
`define ADW_RST_CONTROL      8'h02
`define ADW_RST_BYTE         8'h00
`define ADW_RST_WORD         16'h0000

// control fields
`define ADW_CTL_DIFF_BIT     0
`define ADW_CTL_ENABLE_BIT   1
`define ADW_CTL_MASK         8'h03

// status fields
`define ADW_STS_HIT_BIT      0
`define ADW_STS_OVF_BIT      1

// hit counter
`define ADW_CNT_MAX          8'hFF
`define ADW_CNT_ONE          8'h01

`endif

// ---- hdl/adw_pkg.sv ----
package adw_pkg;

  // one conversion result from the converter data path
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } adw_result_t;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wrData;
    logic       wrEn;
    logic       rdEn;
  } adw_reg_req_t;

  // limit pair handed to the comparator
  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] lower;
  } adw_limits_t;

endpackage

// ---- hdl/adw_byte_pair.sv ----
`timescale 1ns/1ps
`include "adw_regs.svh"

// a 16-bit word written through separate high and low byte registers
module adw_byte_pair #(
  parameter logic [7:0] RST_HIGH = 8'h00,
  parameter logic [7:0] RST_LOW  = 8'h00
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // byte writes
  input  wire logic        wrHigh,
  input  wire logic        wrLow,
  input  wire logic [7:0]  wrData,
  // assembled word
  output logic      [15:0] word
);

  logic [7:0] high_reg;
  logic [7:0] low_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      high_reg <= RST_HIGH;
    end else if (wrHigh) begin
      high_reg <= wrData;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      low_reg <= RST_LOW;
    end else if (wrLow) begin
      low_reg <= wrData;
    end
  end

  // no shadowing: a half-written limit is live at once
  assign word = {high_reg, low_reg};

endmodule

// ---- hdl/adw_window_compare.sv ----
`timescale 1ns/1ps

// window test of one result against the limit pair
module adw_window_compare (
  // operands
  input  wire logic              diffMode,
  input  wire logic [15:0]       result,
  input  wire adw_pkg::adw_limits_t limits,
  // outcome
  output logic                   hit
);

  logic aboveUpper;
  logic belowLower;
  logic upperBelowLower;

  // differential results are signed, single-ended unsigned
  always_comb begin
    if (diffMode) begin
      aboveUpper      = $signed(result) > $signed(limits.upper); // R5
      belowLower      = $signed(result) < $signed(limits.lower);
      upperBelowLower = $signed(limits.upper) < $signed(limits.lower);
    end else begin
      aboveUpper      = result > limits.upper; // R4
      belowLower      = result < limits.lower;
      upperBelowLower = limits.upper < limits.lower;
    end
  end

  // inside or outside chosen only by the limit ordering
  assign hit = upperBelowLower ? (aboveUpper && belowLower) // R8
                               : (aboveUpper || belowLower); // R6

endmodule

// ---- verification/adw_conv_model.sv ----
`timescale 1ns/1ps

// converter side: one valid pulse per request, word scrambled while idle
module adw_conv_model (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  // request from the bench
  input  wire logic          start,
  input  wire logic [15:0]   word,
  // result path
  output adw_pkg::adw_result_t convResult
);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      convResult <= '0;
    end else begin
      convResult.valid <= start;
      // idle word inverts so a stale value is never mistaken for a result
      convResult.word  <= start ? word : ~convResult.word;
    end
  end
endmodule

// ---- verification/adw_window_detector_sva.sv ----
`timescale 1ns/1ps

module adw_wd_sva (
  // clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rstn,
  // register port
  input wire logic [3:0]           regAddr,
  input wire logic [7:0]           regWrData,
  input wire logic                 regWrEn,
  input wire logic                 regRdEn,
  input wire logic [7:0]           regRdData,
  // result path and status
  input wire adw_pkg::adw_result_t convResult,
  input wire logic                 windowHitFlag,
  input wire logic                 windowHitPulse,
  input wire logic                 diffModeOut
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire clrReq = regWrEn && regAddr == 4'h5 && regWrData[0];
  wire ctlWr = regWrEn && regAddr == 4'h4;
  sequence ctl_wr;
    ctlWr;
  endsequence
  pulse_flag_a: assert property (windowHitPulse |-> windowHitFlag)
    else $error("hit pulse without flag");
  pulse_cause_a: assert property (!convResult.valid |=> !windowHitPulse)
    else $error("hit pulse without result");
  flag_set_a: assert property ($rose(windowHitFlag) |-> windowHitPulse)
    else $error("flag set without hit");
  flag_hold_a: assert property (windowHitFlag && !clrReq |=> windowHitFlag)
    else $error("flag lost");
  flag_clear_a: assert property (clrReq && !convResult.valid |=> !windowHitFlag)
    else $error("flag not cleared");
  poll_read_a: assert property (regRdEn && regAddr == 4'h5 && !convResult.valid
    |=> regRdData[0] == windowHitFlag) else $error("status bit differs from flag");
  read_idle_a: assert property (!regRdEn |=> regRdData == 8'h00)
    else $error("read data outside read slot");
  diff_mode_a: assert property (ctl_wr ##1 !ctlWr |=>
    diffModeOut == $past(regWrData[0], 2)) else $error("mode output wrong");
endmodule

// ---- verification/adw_window_detector_tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end

module adw_window_detector_tb;
  logic ref_clk = 0, rstn = 0, regWrEn = 0, regRdEn = 0, start = 0, dm = 0, en = 1, flg = 0;
  logic [3:0] regAddr = 0;
  logic [7:0] regWrData = 0, regRdData;
  logic [15:0] cw = 0, seed = 16'h0049, up = 16'hFFFF, lo = 16'h0000, tmp;
  logic windowHitFlag, windowHitPulse, diffModeOut;
  logic ov = 0;
  logic [7:0] nh = 0;
  logic [15:0] lw = 0;
  adw_pkg::adw_result_t convResult;
  int n_fail = 0, n_checks = 0, cyc = 0;
  logic [7:0] rv[10] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [15:0] dv[7] = '{16'hFFFE, 16'hFFFF, 16'h0000, 16'h1000, 16'h1001, 16'h8000, 16'h7FFF};
  always #2.5 ref_clk = ~ref_clk;
  adw_window_detector dut_u(.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .convResult(convResult), .windowHitFlag(windowHitFlag),
    .windowHitPulse(windowHitPulse), .diffModeOut(diffModeOut));
  adw_conv_model conv_u(.ref_clk(ref_clk), .rstn(rstn), .start(start), .word(cw),
    .convResult(convResult));
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function bit hitf(input logic [15:0] w);
    int r, u, l;
    r = dm ? int'($signed(w)) : int'(w);
    u = dm ? int'($signed(up)) : int'(up);
    l = dm ? int'($signed(lo)) : int'(lo);
    return (u < l) ? (r > u && r < l) : (r > u || r < l);
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk); regAddr <= a; regWrData <= d; regWrEn <= 1;
    @(posedge ref_clk); regWrEn <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk); regAddr <= a; regRdEn <= 1;
    @(posedge ref_clk); regRdEn <= 0;
    #1 `CHK(regRdData, e)
  endtask
  task automatic lim(input logic [15:0] u, input logic [15:0] l);
    wr(4'h0, u[15:8]); wr(4'h1, u[7:0]); wr(4'h2, l[15:8]); wr(4'h3, l[7:0]);
    up = u; lo = l;
  endtask
  task automatic conv(input logic [15:0] w);
    bit h;
    h = en && hitf(w);
    @(posedge ref_clk); start <= 1; cw <= w;
    @(posedge ref_clk); start <= 0;
    @(posedge ref_clk); #1;
    flg = flg | h;
    if (en) lw = w;
    if (h && nh == 8'hFF) ov = 1;
    else if (h) nh++;
    `CHK(windowHitPulse, h)
    `CHK(windowHitFlag, flg)
    `CHK(diffModeOut, dm)
  endtask
  task automatic complete_run();
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1;
    foreach (rv[i]) rd(4'(i), rv[i]);
    conv(16'h0000); conv(16'hFFFF);
    lim(16'h0FFE, 16'h2001);
    foreach (dv[i]) conv(dv[i] + 16'h1000);
    rd(4'h5, {6'h0, ov, flg});
    rd(4'h6, lw[15:8]);
    rd(4'h7, lw[7:0]);
    rd(4'h8, nh);
    wr(4'h5, 8'h01); flg = 0;
    rd(4'h5, {6'h0, ov, flg});
    wr(4'h4, 8'h03); dm = 1;
    wr(4'h8, 8'hFF); nh = 8'hFF;
    lim(16'h1000, 16'hFFFF);
    foreach (dv[i]) conv(dv[i]);
    rd(4'h5, {6'h0, ov, flg});
    wr(4'h5, 8'h02); ov = 0;
    rd(4'h5, {6'h0, ov, flg});
    rd(4'h8, nh);
    lim(16'hFFFF, 16'h1000); conv(16'h0000); conv(16'hFFFF);
    // enable off: a result that would hit must be ignored
    wr(4'h4, 8'h00); en = 0; dm = 0; conv(16'h0000);
    for (int i = 0; i < 48; i++) begin
      if (i % 6 == 0) begin
        wr(4'h5, 8'h01); flg = 0;
        seed = lfsr(seed); tmp = seed; seed = lfsr(seed);
        dm = seed[0]; en = 1; wr(4'h4, {6'h0, 1'b1, dm});
        lim(tmp, seed);
      end
      seed = lfsr(seed);
      conv(seed);
    end
    complete_run();
  end
endmodule

bind adw_window_detector adw_wd_sva chk_u (
  .ref_clk        (ref_clk),
  .rstn           (rstn),
  .regAddr        (regAddr),
  .regWrData      (regWrData),
  .regWrEn        (regWrEn),
  .regRdEn        (regRdEn),
  .regRdData      (regRdData),
  .convResult     (convResult),
  .windowHitFlag  (windowHitFlag),
  .windowHitPulse (windowHitPulse),
  .diffModeOut    (diffModeOut)
);
